// ### rtl/lwcm_pkg.sv
// Package of the low-power wake-up clock mask block: register map,
// field layout, reset values, timing constants and carrier types.
// Assumes a single 125 MHz system clock.
package lwcm_pkg;

  localparam int unsigned CLK_MHZ = 125;

  // Times in nanoseconds
  localparam int unsigned OVERSHOOT_NS = 6000;
  localparam int unsigned MASK_SLOW_NS = 150000;
  localparam int unsigned MASK_FAST_NS = 2000;
  localparam int unsigned SETTLE_FAST_NS = 2000;
  localparam int unsigned SETTLE_SLOW_NS = 150000;
  localparam int unsigned ENTRY_GUARD_NS = 1000;

  // Least times round up, at least one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned OVERSHOOT_CYC = ns_to_cyc(OVERSHOOT_NS);
  localparam int unsigned MASK_SLOW_CYC = ns_to_cyc(MASK_SLOW_NS);
  localparam int unsigned MASK_FAST_CYC = ns_to_cyc(MASK_FAST_NS);
  localparam int unsigned SETTLE_FAST_CYC = ns_to_cyc(SETTLE_FAST_NS);
  localparam int unsigned SETTLE_SLOW_CYC = ns_to_cyc(SETTLE_SLOW_NS);
  localparam int unsigned ENTRY_GUARD_CYC = ns_to_cyc(ENTRY_GUARD_NS);

  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] LOW_SUP_OFS = 8'h00;
  localparam logic [7:0] HIGH_SUP_OFS = 8'h04;
  localparam logic [7:0] CLK_DIV_OFS = 8'h08;
  localparam logic [7:0] CORE_LVL_OFS = 8'h0c;
  localparam logic [7:0] STATE_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h18;
  localparam logic [7:0] IRQ_EN_OFS = 8'h1c;

  // Sleep level codes
  localparam logic [2:0] SLEEP_TWO = 3'h2;
  localparam logic [2:0] SLEEP_THREE = 3'h3;
  localparam logic [2:0] SLEEP_FOUR = 3'h4;

  // Digital oscillator thresholds in 100 kHz units, per core level
  localparam logic [3:0][7:0] OSC_THR = {8'h7d, 8'h64, 8'h4b, 8'h32};

  // Interrupt bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_SETTLE = 1;
  localparam int IRQ_CORE_RST = 2;
  localparam int IRQ_WAKE_FAIL = 3;
  localparam int IRQ_W = 4;

  // Low-side supervisor control, bits 3:0
  typedef struct packed {
    logic low_monitor_full_perf;
    logic low_supervisor_full_perf;
    logic low_monitor_enable;
    logic low_supervisor_enable;
  } lwcm_low_sup_t;

  localparam lwcm_low_sup_t LOW_SUP_RST = 4'h3;

  // Clock divider control, bits 15:0
  typedef struct packed {
    logic [7:0] osc_freq;
    logic [1:0] spare;
    logic sub_clock_request_enable;
    logic sub_from_osc;
    logic main_from_osc;
    logic [2:0] main_clock_divide;
  } lwcm_clk_t;

  localparam lwcm_clk_t CLK_RST = 16'h2038;

endpackage

// ### rtl/lwcm_wakeup_mask.sv
// Wake-up sequencer: masks CPU execution and the main clock after
// deep sleep, times supervisor settling, raises the core reset and
// models the wake-up failure hazard. APB slave for its registers.
// Assumes all inputs are synchronous to clk_i.
`timescale 1ns/100ps

// Behaviour
// - Oscillator may overshoot up to 6 us after sleep three or four.
// - Normal-performance low side holds CPU off 150 us on deep wake.
// - Low side off or full-performance shortens the wake mask to 2 us.
// - Sub-main clock from the oscillator is never gated at wake.
// - Full-performance low supervisor settles its comparator in 2 us.
// - Core level not reached when settling ends raises a reset.
// - Interrupt within 1 us of deep entry may leave device stuck.
// - Stuck wake-up is cleared by reset or power-up clear.
module lwcm_wakeup_mask #(
  parameter int unsigned MASK_SLOW = lwcm_pkg::MASK_SLOW_CYC,
  parameter int unsigned SETTLE_SLOW = lwcm_pkg::SETTLE_SLOW_CYC
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_enter_i,
  input wire logic [2:0] sleep_level_i,
  input wire logic wake_event_i,
  input wire logic core_level_ok_i,
  input wire logic power_up_clear_i,
  output logic cpu_hold_o,
  output logic main_clock_gate_o,
  output logic sub_clock_gate_o,
  output logic overshoot_o,
  output logic core_reset_o,
  output logic wake_failed_o,
  output logic irq_o
);

  localparam int W = lwcm_pkg::CNT_W;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE = 4'h4,
    ST_FAIL = 4'h8
  } lwcm_state_t;

  function automatic logic [W-1:0] cyc(input int unsigned n);
    return W'(n);
  endfunction

  // Registers
  lwcm_pkg::lwcm_low_sup_t low_sup_reg, low_sup_next;
  logic high_sup_reg, high_sup_next;
  lwcm_pkg::lwcm_clk_t clk_reg, clk_next;
  logic [1:0] core_lvl_reg, core_lvl_next;
  logic [lwcm_pkg::IRQ_W-1:0] irq_stat_reg, irq_stat_next;
  logic [lwcm_pkg::IRQ_W-1:0] irq_en_reg, irq_en_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;

  // Sequencer state
  lwcm_state_t state_reg, state_next;
  logic [W-1:0] mask_cnt_reg, mask_cnt_next;
  logic [W-1:0] guard_cnt_reg, guard_cnt_next;
  logic [W-1:0] shoot_cnt_reg, shoot_cnt_next;
  logic [W-1:0] settle_cnt_reg, settle_cnt_next;
  logic low_pend_reg, low_pend_next;
  logic high_pend_reg, high_pend_next;
  logic core_chk_reg, core_chk_next;
  logic hazard_reg, hazard_next;
  logic deep_reg, deep_next;
  logic hold_reg, hold_next;
  logic mgate_reg, mgate_next;
  logic sgate_reg, sgate_next;
  logic shoot_reg, shoot_next;
  logic core_rst_reg, core_rst_next;
  logic fail_reg, fail_next;

  logic wr_en, rd_en, fast_cfg, deep_entry, sleep_entry;
  logic [lwcm_pkg::IRQ_W-1:0] irq_set;

  assign wr_en = psel_i && penable_i && pready_reg && pwrite_i;
  assign rd_en = psel_i && penable_i && !pready_reg && !pwrite_i;
  assign sleep_entry = sleep_enter_i &&
    (sleep_level_i == lwcm_pkg::SLEEP_TWO || deep_entry);
  assign deep_entry = sleep_level_i == lwcm_pkg::SLEEP_THREE ||
    sleep_level_i == lwcm_pkg::SLEEP_FOUR;
  // Low side off, or both in full performance, gives the short mask
  assign fast_cfg = (!low_sup_reg.low_supervisor_enable &&
    !low_sup_reg.low_monitor_enable) ||
    (low_sup_reg.low_supervisor_full_perf &&
    low_sup_reg.low_monitor_full_perf);

  // Wake-up sequencer
  always_comb begin
    state_next = state_reg;
    mask_cnt_next = mask_cnt_reg;
    guard_cnt_next = guard_cnt_reg;
    shoot_cnt_next = shoot_cnt_reg;
    hazard_next = hazard_reg;
    deep_next = deep_reg;
    irq_set = '0;
    if (shoot_cnt_reg != '0) begin
      shoot_cnt_next = shoot_cnt_reg - 1'b1;
    end
    if (guard_cnt_reg != '0) begin
      guard_cnt_next = guard_cnt_reg - 1'b1;
    end
    unique case (state_reg)
      ST_ACTIVE: begin
        if (sleep_entry) begin
          state_next = ST_SLEEP;
          deep_next = deep_entry;
          guard_cnt_next = cyc(lwcm_pkg::ENTRY_GUARD_CYC);
          hazard_next = low_pend_reg || high_pend_reg;
        end
      end
      ST_SLEEP: begin
        if (wake_event_i) begin
          if (hazard_reg && guard_cnt_reg != '0) begin
            state_next = ST_FAIL;
            irq_set[lwcm_pkg::IRQ_WAKE_FAIL] = 1'b1;
          end else begin
            state_next = ST_WAKE;
            if (!deep_reg) begin
              mask_cnt_next = cyc(1);
            end else begin
              mask_cnt_next = fast_cfg ? cyc(lwcm_pkg::MASK_FAST_CYC) :
                cyc(MASK_SLOW);
              shoot_cnt_next = cyc(lwcm_pkg::OVERSHOOT_CYC);
            end
          end
        end
      end
      ST_WAKE: begin
        mask_cnt_next = mask_cnt_reg - 1'b1;
        if (mask_cnt_reg == cyc(1)) begin
          state_next = ST_ACTIVE;
          irq_set[lwcm_pkg::IRQ_WAKE] = 1'b1;
        end
      end
      ST_FAIL: begin
        if (power_up_clear_i) begin
          state_next = ST_ACTIVE;
        end
      end
    endcase
    // Outputs follow the next state so they come from flip-flops
    hold_next = state_next != ST_ACTIVE;
    mgate_next = state_next != ST_ACTIVE;
    // sub-main clock ungated when from oscillator
    sgate_next = (state_next == ST_SLEEP || state_next == ST_FAIL) &&
      !clk_reg.sub_from_osc && !clk_reg.sub_clock_request_enable;
    shoot_next = shoot_cnt_next != '0 && clk_reg.main_from_osc;
    fail_next = state_next == ST_FAIL;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_ACTIVE;
      mask_cnt_reg <= '0;
      guard_cnt_reg <= '0;
      shoot_cnt_reg <= '0;
      hazard_reg <= 1'b0;
      deep_reg <= 1'b0;
      hold_reg <= 1'b0;
      mgate_reg <= 1'b0;
      sgate_reg <= 1'b0;
      shoot_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mask_cnt_reg <= mask_cnt_next;
      guard_cnt_reg <= guard_cnt_next;
      shoot_cnt_reg <= shoot_cnt_next;
      hazard_reg <= hazard_next;
      deep_reg <= deep_next;
      hold_reg <= hold_next;
      mgate_reg <= mgate_next;
      sgate_reg <= sgate_next;
      shoot_reg <= shoot_next;
      fail_reg <= fail_next;
    end
  end

  // Supervisor settling and core level check
  always_comb begin
    settle_cnt_next = settle_cnt_reg;
    low_pend_next = low_pend_reg;
    high_pend_next = high_pend_reg;
    core_chk_next = core_chk_reg;
    core_rst_next = 1'b0;
    if (settle_cnt_reg != '0) begin
      settle_cnt_next = settle_cnt_reg - 1'b1;
      if (settle_cnt_reg == cyc(1)) begin
        low_pend_next = 1'b0;
        high_pend_next = 1'b0;
        core_chk_next = 1'b0;
        core_rst_next = core_chk_reg && !core_level_ok_i;
      end
    end
    if (wr_en && (paddr_i == lwcm_pkg::LOW_SUP_OFS ||
        paddr_i == lwcm_pkg::HIGH_SUP_OFS ||
        paddr_i == lwcm_pkg::CORE_LVL_OFS)) begin
      settle_cnt_next = (paddr_i == lwcm_pkg::LOW_SUP_OFS ? pwdata_i[2] :
        low_sup_reg.low_supervisor_full_perf) ?
        cyc(lwcm_pkg::SETTLE_FAST_CYC) : cyc(SETTLE_SLOW);
      low_pend_next = low_pend_next || paddr_i != lwcm_pkg::HIGH_SUP_OFS;
      high_pend_next = high_pend_next || paddr_i == lwcm_pkg::HIGH_SUP_OFS;
      core_chk_next = paddr_i == lwcm_pkg::CORE_LVL_OFS &&
        pwdata_i[1:0] > core_lvl_reg;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_cnt_reg <= '0;
      low_pend_reg <= 1'b0;
      high_pend_reg <= 1'b0;
      core_chk_reg <= 1'b0;
      core_rst_reg <= 1'b0;
    end else begin
      settle_cnt_reg <= settle_cnt_next;
      low_pend_reg <= low_pend_next;
      high_pend_reg <= high_pend_next;
      core_chk_reg <= core_chk_next;
      core_rst_reg <= core_rst_next;
    end
  end

  // APB register file and interrupts
  always_comb begin
    low_sup_next = low_sup_reg;
    high_sup_next = high_sup_reg;
    clk_next = clk_reg;
    core_lvl_next = core_lvl_reg;
    irq_en_next = irq_en_reg;
    irq_stat_next = irq_stat_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel_i && penable_i && !pready_reg;
    if (wr_en) begin
      unique case (paddr_i)
        lwcm_pkg::LOW_SUP_OFS: low_sup_next = pwdata_i[3:0];
        lwcm_pkg::HIGH_SUP_OFS: high_sup_next = pwdata_i[0];
        lwcm_pkg::CLK_DIV_OFS: clk_next = pwdata_i[15:0];
        lwcm_pkg::CORE_LVL_OFS: core_lvl_next = pwdata_i[1:0];
        lwcm_pkg::IRQ_CLR_OFS:
          irq_stat_next = irq_stat_reg & ~pwdata_i[lwcm_pkg::IRQ_W-1:0];
        lwcm_pkg::IRQ_EN_OFS: irq_en_next = pwdata_i[lwcm_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    if (psel_i && penable_i && !pready_reg) begin
      prdata_next = '0;
      unique case (paddr_i)
        lwcm_pkg::LOW_SUP_OFS: prdata_next[3:0] = low_sup_reg;
        lwcm_pkg::HIGH_SUP_OFS: prdata_next[0] = high_sup_reg;
        lwcm_pkg::CLK_DIV_OFS: prdata_next[15:0] = clk_reg;
        lwcm_pkg::CORE_LVL_OFS: prdata_next[1:0] = core_lvl_reg;
        lwcm_pkg::STATE_OFS: prdata_next[4:0] = {clk_reg.main_from_osc &&
          clk_reg.osc_freq > lwcm_pkg::OSC_THR[core_lvl_reg] && fast_cfg,
          fail_reg, hold_reg, high_pend_reg, low_pend_reg};
        lwcm_pkg::IRQ_STAT_OFS:
          prdata_next[lwcm_pkg::IRQ_W-1:0] = irq_stat_reg;
        lwcm_pkg::IRQ_EN_OFS: prdata_next[lwcm_pkg::IRQ_W-1:0] = irq_en_reg;
        lwcm_pkg::IRQ_CLR_OFS: ;
        default: pslverr_next = 1'b1;
      endcase
      prdata_next = rd_en ? prdata_next : '0;
    end
    // Hardware set wins over a software clear
    irq_stat_next = irq_stat_next | irq_set |
      {1'b0, core_rst_next, settle_cnt_reg == cyc(1), 1'b0};
    irq_next = |(irq_stat_next & irq_en_next);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_sup_reg <= lwcm_pkg::LOW_SUP_RST;
      high_sup_reg <= 1'b0;
      clk_reg <= lwcm_pkg::CLK_RST;
      core_lvl_reg <= 2'h0;
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      low_sup_reg <= low_sup_next;
      high_sup_reg <= high_sup_next;
      clk_reg <= clk_next;
      core_lvl_reg <= core_lvl_next;
      irq_stat_reg <= irq_stat_next;
      irq_en_reg <= irq_en_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign cpu_hold_o = hold_reg;
  assign main_clock_gate_o = mgate_reg;
  assign sub_clock_gate_o = sgate_reg;
  assign overshoot_o = shoot_reg;
  assign core_reset_o = core_rst_reg;
  assign wake_failed_o = fail_reg;
  assign irq_o = irq_reg;

endmodule

// ### verif/lwcm_monitor.sv
// Checker of the wake-up mask block, bound to its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module lwcm_monitor #(
  parameter int unsigned MASK_SLOW = 40
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sleep_enter_i,
  input wire logic [2:0] sleep_level_i,
  input wire logic wake_event_i,
  input wire logic power_up_clear_i,
  input wire logic cpu_hold_o,
  input wire logic main_clock_gate_o,
  input wire logic overshoot_o,
  input wire logic core_reset_o,
  input wire logic wake_failed_o
);
  localparam int unsigned FAST = lwcm_pkg::MASK_FAST_CYC;
  localparam int unsigned LIM = ((MASK_SLOW > FAST) ? MASK_SLOW : FAST) + 2;
  logic armed_reg, armed_next;
  logic [15:0] mcnt_reg, mcnt_next, ocnt_reg, ocnt_next;
  always_comb begin
    armed_next = armed_reg;
    if (!cpu_hold_o || wake_failed_o) begin
      armed_next = 1'b0;
    end else if (wake_event_i) begin
      armed_next = 1'b1;
    end
    mcnt_next = armed_reg ? mcnt_reg + 16'h0001 : 16'h0000;
    ocnt_next = overshoot_o ? ocnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_reg <= 1'b0;
      mcnt_reg <= 16'h0000;
      ocnt_reg <= 16'h0000;
    end else begin
      armed_reg <= armed_next;
      mcnt_reg <= mcnt_next;
      ocnt_reg <= ocnt_next;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  hold_on_entry_a:
  assert property (sleep_enter_i && !cpu_hold_o &&
    sleep_level_i inside {3'h2, 3'h3, 3'h4} |=> cpu_hold_o)
    else $error("hold not raised on entry");
  gate_follows_hold_a:
  assert property (main_clock_gate_o == cpu_hold_o)
    else $error("main gate differs from hold");
  mask_bound_a:
  assert property (mcnt_reg <= 16'(LIM)) else $error("wake mask too long");
  reset_pulse_a:
  assert property (core_reset_o |=> !core_reset_o)
    else $error("core reset too long");
  overshoot_start_a:
  assert property ($rose(overshoot_o) |->
    $past(wake_event_i) || $past(wake_event_i, 2))
    else $error("overshoot without wake");
  overshoot_len_a:
  assert property (ocnt_reg <= 16'(lwcm_pkg::OVERSHOOT_CYC + 1))
    else $error("overshoot too long");
  fail_sticky_a:
  assert property (wake_failed_o && !power_up_clear_i &&
    !$past(power_up_clear_i) |=> wake_failed_o)
    else $error("fail state left early");
  fail_clear_a:
  assert property (power_up_clear_i && wake_failed_o |-> ##[1:2]
    !wake_failed_o) else $error("clear did not end fail");
endmodule

bind lwcm_wakeup_mask lwcm_monitor #(.MASK_SLOW(MASK_SLOW)) lwcm_monitor_inst (
  .clk_i, .reset_n_i, .sleep_enter_i, .sleep_level_i, .wake_event_i,
  .power_up_clear_i, .cpu_hold_o, .main_clock_gate_o, .overshoot_o,
  .core_reset_o, .wake_failed_o);

// ### verif/lwcm_supply_model.sv
// Core supply model: after a raise request the core voltage
// needs RAMP cycles to reach the new level. One clock.
`timescale 1ns/100ps
module lwcm_supply_model #(
  parameter int RAMP = 300
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic raise_i,
  output logic level_ok_o
);
  int cnt;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
    end else if (raise_i) begin
      cnt <= RAMP;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign level_ok_o = (cnt == 0);
endmodule

// ### verif/lwcm_wakeup_mask_test.sv
// Testbench of the wake-up mask block: firmware sequences over APB,
// sleep and wake pulses, core supply model. Shortened slow counts.
`timescale 1ns/100ps
module lwcm_wakeup_mask_test;
  localparam int MS = 40;
  localparam int SS = 400;
  localparam int FAST = lwcm_pkg::MASK_FAST_NS / 8;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic sleep_enter_i = 1'b0, wake_event_i = 1'b0, power_up_clear_i = 1'b0;
  logic [2:0] sleep_level_i = 3'h0;
  logic raise = 1'b0;
  logic core_level_ok_i, pready_o, pslverr_o, cpu_hold_o, main_clock_gate_o;
  logic sub_clock_gate_o, overshoot_o, core_reset_o, wake_failed_o, irq_o;
  logic [31:0] prdata_o, rd;
  logic err;
  int n_fail = 0;
  int num_checks = 0;
  int n;

  always #4 clk_i = ~clk_i;

  lwcm_wakeup_mask #(.MASK_SLOW(MS), .SETTLE_SLOW(SS)) lwcm_wakeup_mask_inst (
    .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .sleep_enter_i, .sleep_level_i,
    .wake_event_i, .core_level_ok_i, .power_up_clear_i, .cpu_hold_o,
    .main_clock_gate_o, .sub_clock_gate_o, .overshoot_o, .core_reset_o,
    .wake_failed_o, .irq_o);
  lwcm_supply_model #(.RAMP(300)) lwcm_supply_model_inst (
    .clk_i, .reset_n_i, .raise_i(raise), .level_ok_o(core_level_ok_i));

  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (pready_o !== 1'b1 && i < 20);
    if (pready_o !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end else begin
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic settle();
    int i;
    i = 0;
    do begin
      apb(1'b0, lwcm_pkg::STATE_OFS, 32'h0);
      i++;
    end while (rd[1:0] !== 2'b00 && i < 300);
    check("settle flags", {30'h0, rd[1:0]}, 32'h0);
  endtask

  task automatic nap(input logic [2:0] lvl, input int gap, input logic sub,
                     input int lim);
    sleep_level_i <= lvl;
    sleep_enter_i <= 1'b1;
    @(posedge clk_i);
    sleep_enter_i <= 1'b0;
    @(negedge clk_i);
    check("hold", {31'h0, cpu_hold_o}, 32'h1);
    check("main gate", {31'h0, main_clock_gate_o}, 32'h1);
    check("sub gate", {31'h0, sub_clock_gate_o}, {31'h0, sub});
    repeat (gap) @(posedge clk_i);
    wake_event_i <= 1'b1;
    @(posedge clk_i);
    wake_event_i <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (cpu_hold_o !== 1'b0 && n < lim);
  endtask

  task automatic raise_core(input logic [31:0] lvl, input int lim);
    apb(1'b1, lwcm_pkg::CORE_LVL_OFS, lvl);
    raise <= 1'b1;
    @(posedge clk_i);
    raise <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (core_reset_o !== 1'b1 && n < lim);
    tick(1);
  endtask

  task automatic t_regs();
    apb(1'b0, lwcm_pkg::CLK_DIV_OFS, 32'h0);
    check("clk ctrl", rd, 32'(lwcm_pkg::CLK_RST));
    apb(1'b0, lwcm_pkg::LOW_SUP_OFS, 32'h0);
    check("low sup", rd, 32'(lwcm_pkg::LOW_SUP_RST));
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
  endtask

  task automatic t_light();
    nap(lwcm_pkg::SLEEP_TWO, 3, 1'b0, 50);
    check("light mask", 32'(n >= 1 && n <= 3), 32'h1);
    check("light overshoot", {31'h0, overshoot_o}, 32'h0);
    tick(1);
  endtask

  task automatic t_slow();
    apb(1'b1, lwcm_pkg::CLK_DIV_OFS, 32'h0000_2039);
    apb(1'b1, lwcm_pkg::IRQ_EN_OFS, 32'h1);
    nap(lwcm_pkg::SLEEP_THREE, 20, 1'b0, 200);
    check("slow mask", 32'(n >= MS && n <= MS + 2), 32'h1);
    check("overshoot", {31'h0, overshoot_o}, 32'h1);
    tick(1);
    apb(1'b0, lwcm_pkg::IRQ_STAT_OFS, 32'h0);
    check("wake status", rd, 32'h1);
    @(negedge clk_i);
    check("irq on", {31'h0, irq_o}, 32'h1);
    tick(1);
    apb(1'b1, lwcm_pkg::IRQ_EN_OFS, 32'h0);
    tick(2);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    apb(1'b1, lwcm_pkg::IRQ_CLR_OFS, 32'h1);
    apb(1'b0, lwcm_pkg::IRQ_STAT_OFS, 32'h0);
    check("cleared", rd, 32'h0);
    tick(32);
    apb(1'b1, lwcm_pkg::CLK_DIV_OFS, 32'h0000_2038);
    tick(800);
    check("overshoot end", {31'h0, overshoot_o}, 32'h0);
  endtask

  task automatic t_fast();
    apb(1'b1, lwcm_pkg::LOW_SUP_OFS, 32'h0);
    settle();
    apb(1'b1, lwcm_pkg::CLK_DIV_OFS, 32'h0000_2008);
    nap(lwcm_pkg::SLEEP_FOUR, 20, 1'b1, 400);
    check("fast mask", 32'(n >= FAST && n <= FAST + 2), 32'h1);
    tick(800);
  endtask

  task automatic t_fail();
    apb(1'b1, lwcm_pkg::LOW_SUP_OFS, 32'h3);
    nap(lwcm_pkg::SLEEP_FOUR, 10, 1'b1, 60);
    check("failed", {31'h0, wake_failed_o}, 32'h1);
    check("fail hold", {31'h0, cpu_hold_o}, 32'h1);
    tick(1);
    power_up_clear_i <= 1'b1;
    tick(1);
    power_up_clear_i <= 1'b0;
    tick(3);
    check("fail gone", {31'h0, wake_failed_o}, 32'h0);
    check("hold gone", {31'h0, cpu_hold_o}, 32'h0);
    settle();
    apb(1'b0, lwcm_pkg::IRQ_STAT_OFS, 32'h0);
    check("fail status", rd, 32'h0000_000b);
    apb(1'b1, lwcm_pkg::IRQ_CLR_OFS, 32'h0000_000f);
  endtask

  task automatic t_core();
    apb(1'b1, lwcm_pkg::LOW_SUP_OFS, 32'h0000_000f);
    settle();
    raise_core(32'h1, 400);
    check("fast reset", 32'(n >= FAST - 4 && n <= FAST + 2), 32'h1);
    apb(1'b1, lwcm_pkg::LOW_SUP_OFS, 32'h3);
    settle();
    raise_core(32'h2, SS + 50);
    check("no reset", n, SS + 50);
  endtask

  initial begin
    tick(6);
    reset_n_i <= 1'b1;
    tick(1);
    t_regs();
    t_light();
    t_slow();
    t_fast();
    t_fail();
    t_core();
    tally_and_finish();
  end
endmodule
